// ---- design/usc_ctrl.sv ----
// Register file and control of the low-speed serial engine's MCU side.
// Assumes engine events arrive on core_clk; bus pins arrive asynchronously.
// Overview of operation
// - Host resume sets resume flag, raises interrupt
// - Resume flag holds 20ms, clears with suspend
// - Suspend flag from engine; interrupt on change
// - Wake command held 2us signals host
// - Legacy mode maps minus/plus lines to data/clock
// - Firmware samples and drives legacy pins
// - Legacy input reads zero when output zero
// - Serial mode: engine drives lines; selects reset zero
// - Address register: wake enable, 7-bit address
// - Accessed bits set per endpoint host access
// - Direction bits; low pulse resets toggles
// - Enable register for endpoints 1, 2
// - Deferred address adopted after successful IN
// - ENDPOINT0_DATA_PORT and CRC error flags, firmware cleared
// - OUT flag set; cleared by firmware or SETUP
// - IN and NAK flags show engine state
// - NAK mask gates endpoint 0 interrupts
// - FIFO control: bus-reset clear, select, flush
// - FIFO request/ready handshake for byte transfers
// - Setup and empty-packet flags, firmware cleared
// - Bus reset flag set, interrupt raised
// - Legacy output bits reset to one
module usc_ctrl
  import usc_pkg::*;
#(
  parameter int RESUME_CLKS = USC_RESUME_CLKS
) (
  input  wire logic          core_clk,    // 250 MHz core clock
  input  wire logic          reset,       // Synchronous, active high
  input  wire logic [7:0]    reg_addr,    // MCU register address
  input  wire logic          reg_wr,      // Write strobe
  input  wire logic          reg_rd,      // Read strobe
  input  wire logic [7:0]    reg_wdata,   // Write data
  output logic [7:0]         reg_rdata,   // Read data, one cycle later
  input  wire usc_evt_t      evt,         // Engine events and levels
  input  wire logic [7:0]    fifo_rdata,  // Byte from selected FIFO
  output usc_fifo_cmd_t      fifo_cmd,    // FIFO command
  output logic               usb_irq,     // One-cycle interrupt pulse
  output logic [6:0]         dev_addr,    // Address in use by engine
  output logic               wake_enable, // Remote wake-up allowed
  output logic               wake_host,   // Pulse: send wake-up
  output logic               toggle_rst,  // Pulse: toggles to DATA0
  output logic [2:0]         ep_dir,      // 1 = IN
  output logic [2:0]         ep_en,       // Endpoint enables
  output logic [2:0]         ep_halt,     // Endpoint stall
  output logic               nak_mask,    // Ep0 NAK interrupt mask
  input  wire logic          eng_dp_o,    // Engine drive, plus line
  input  wire logic          eng_dm_o,    // Engine drive, minus line
  input  wire logic          eng_oe,      // Engine drive enable
  output logic               line_dp_s,   // Synchronised plus line
  output logic               line_dm_s,   // Synchronised minus line
  input  wire logic          dp_i,        // Plus line / legacy clock
  output logic               dp_o,        // Plus line drive value
  output logic               dp_oe,       // Plus line drive enable
  input  wire logic          dm_i,        // Minus line / legacy data
  output logic               dm_o,        // Minus line drive value
  output logic               dm_oe        // Minus line drive enable
);

  // Register write and read decode
  function automatic logic hit(input logic [7:0] ofs);
    return reg_addr == ofs;
  endfunction

  logic wr_status, wr_select, wr_dir, wr_addr, wr_halt;
  logic wr_eng, wr_fifo, wr_en, data_hit;
  assign wr_status = reg_wr && reg_addr == USC_OFS_STATUS;
  assign wr_select = reg_wr && reg_addr == USC_OFS_SELECT;
  assign wr_dir    = reg_wr && reg_addr == USC_OFS_EP_DIR;
  assign wr_addr   = reg_wr && reg_addr == USC_OFS_ADDR;
  assign wr_halt   = reg_wr && reg_addr == USC_OFS_EP_HALT;
  assign wr_eng    = reg_wr && reg_addr == USC_OFS_ENG_STAT;
  assign wr_fifo   = reg_wr && reg_addr == USC_OFS_FIFO_CTL;
  assign wr_en     = reg_wr && reg_addr == USC_OFS_EP_EN;
  assign data_hit  = reg_addr >= USC_OFS_DATA0 &&
                     reg_addr <= USC_OFS_DATA2;

  // Pin synchronisers: first stage feeds only the second
  logic [1:0] dp_sync_reg, dm_sync_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dp_sync_reg <= 2'h0;
      dm_sync_reg <= 2'h0;
    end else begin
      dp_sync_reg <= {dp_sync_reg[0], dp_i};
      dm_sync_reg <= {dm_sync_reg[0], dm_i};
    end
  end
  assign line_dp_s = dp_sync_reg[1];
  assign line_dm_s = dm_sync_reg[1];

  // Mode selects and legacy output bits
  logic leg_sel_reg, ser_sel_reg, dat_out_reg, clk_out_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      leg_sel_reg <= 1'b0;
      ser_sel_reg <= 1'b0;
      dat_out_reg <= 1'b1;
      clk_out_reg <= 1'b1;
    end else begin
      if (wr_select) begin
        leg_sel_reg <= reg_wdata[USC_B_LEG_SEL];
        ser_sel_reg <= reg_wdata[USC_B_SER_SEL];
      end
      if (wr_status) begin
        dat_out_reg <= reg_wdata[USC_B_DAT_OUT];
        clk_out_reg <= reg_wdata[USC_B_CLK_OUT];
      end
    end
  end

  // Line drive: legacy pins are open drain, so a one releases the line
  logic leg_mode, ser_mode;
  assign leg_mode = leg_sel_reg && !ser_sel_reg;
  assign ser_mode = ser_sel_reg && !leg_sel_reg;
  always_comb begin
    dp_o  = 1'b0;
    dm_o  = 1'b0;
    dp_oe = 1'b0;
    dm_oe = 1'b0;
    if (ser_mode) begin
      dp_o  = eng_dp_o;
      dm_o  = eng_dm_o;
      dp_oe = eng_oe;
      dm_oe = eng_oe;
    end else if (leg_mode) begin
      dm_oe = !dat_out_reg;
      dp_oe = !clk_out_reg;
    end
  end

  // Suspend tracking, resume flag with minimum hold time
  logic bus_suspended_flag_reg, resume_reg;
  logic [22:0] resume_cnt_reg;
  logic bus_suspended_flag_change;
  assign bus_suspended_flag_change = evt.suspended != bus_suspended_flag_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      bus_suspended_flag_reg <= 1'b0;
      resume_reg <= 1'b0;
      resume_cnt_reg <= 23'h0;
    end else begin
      bus_suspended_flag_reg <= evt.suspended;
      if (evt.resume_det) begin
        resume_reg <= 1'b1;
        resume_cnt_reg <= 23'(RESUME_CLKS);
      end else begin
        if (resume_cnt_reg != 23'h0)
          resume_cnt_reg <= resume_cnt_reg - 23'h1;
        // Held until the timer ends even if suspend drops early
        if (resume_cnt_reg == 23'h0 && !bus_suspended_flag_reg)
          resume_reg <= 1'b0;
      end
    end
  end

  // Bus reset flag: engine sets, firmware write of zero clears
  logic busrst_reg;
  always_ff @(posedge core_clk) begin
    if (reset)
      busrst_reg <= 1'b0;
    else if (evt.bus_reset)
      busrst_reg <= 1'b1;
    else if (wr_status && !reg_wdata[USC_B_BUSRST])
      busrst_reg <= 1'b0;
  end

  // Wake command: accepted once held for the minimum time
  logic wake_cmd_reg, wake_sent_reg;
  logic [8:0] wake_cnt_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wake_cmd_reg <= 1'b0;
      wake_sent_reg <= 1'b0;
      wake_cnt_reg <= 9'h0;
      wake_host <= 1'b0;
    end else begin
      wake_host <= 1'b0;
      if (wr_status)
        wake_cmd_reg <= reg_wdata[USC_B_WAKE];
      if (!wake_cmd_reg) begin
        wake_cnt_reg <= 9'h0;
        wake_sent_reg <= 1'b0;
      end else if (wake_cnt_reg < 9'(USC_WAKE_CLKS - 1)) begin
        wake_cnt_reg <= wake_cnt_reg + 9'h1;
      end else if (!wake_sent_reg) begin
        wake_sent_reg <= 1'b1;
        wake_host <= wake_enable;
      end
    end
  end

  // Endpoint direction, halt, enable and toggle reset pulse detect
  logic [2:0] dir_reg, halt_reg, en_reg;
  logic [5:0] tog_cnt_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      dir_reg <= USC_RST_EP_DIR;
      halt_reg <= USC_RST_EP_HALT;
      en_reg <= USC_RST_EP_EN;
    end else begin
      if (wr_dir)
        dir_reg <= reg_wdata[2:0];
      if (wr_halt)
        halt_reg <= reg_wdata[2:0];
      if (wr_en)
        en_reg <= reg_wdata[2:0];
    end
  end
  assign ep_dir = dir_reg;
  assign ep_halt = halt_reg;
  assign ep_en = {en_reg[2:1], 1'b1};

  // Short low pulses are ignored; the rising edge ends a valid one
  always_ff @(posedge core_clk) begin
    if (reset) begin
      tog_cnt_reg <= 6'h0;
      toggle_rst <= 1'b0;
    end else begin
      toggle_rst <= dir_reg[0] &&
                    tog_cnt_reg >= 6'(USC_TOG_CLKS);
      if (dir_reg[0])
        tog_cnt_reg <= 6'h0;
      else if (tog_cnt_reg < 6'(USC_TOG_CLKS))
        tog_cnt_reg <= tog_cnt_reg + 6'h1;
    end
  end

  // Address: stored on write, adopted now or after the next IN
  logic [7:0] addr_reg;
  logic adr_def_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      addr_reg <= USC_RST_ADDR;
      dev_addr <= 7'h0;
      adr_def_reg <= 1'b0;
    end else begin
      if (wr_addr)
        addr_reg <= reg_wdata;
      if (wr_addr && !adr_def_reg)
        dev_addr <= reg_wdata[7:1];
      if (wr_eng)
        adr_def_reg <= reg_wdata[USC_B_ADR_DEF];
      if (adr_def_reg && evt.in_done) begin
        dev_addr <= addr_reg[7:1];
        adr_def_reg <= 1'b0;
      end
    end
  end
  assign wake_enable = addr_reg[0];

  // Engine status flags: a set in the clearing cycle wins
  logic fifo_zero_error_reg, crc_reg, out_reg, nmsk_reg;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      fifo_zero_error_reg <= 1'b0;
      crc_reg <= 1'b0;
      out_reg <= 1'b0;
      nmsk_reg <= 1'b0;
    end else begin
      if (wr_eng) begin
        nmsk_reg <= reg_wdata[USC_B_NAK_MSK];
        if (!reg_wdata[USC_B_FIFO_ZERO_ERROR])
          fifo_zero_error_reg <= 1'b0;
        if (!reg_wdata[USC_B_CRC])
          crc_reg <= 1'b0;
        if (!reg_wdata[USC_B_OUT])
          out_reg <= 1'b0;
      end
      if (evt.setup_rx)
        out_reg <= 1'b0;
      if (evt.endpoint0_data_port_err)
        fifo_zero_error_reg <= 1'b1;
      if (evt.crc_err)
        crc_reg <= 1'b1;
      if (evt.out_rx)
        out_reg <= 1'b1;
    end
  end
  assign nak_mask = nmsk_reg;

  // Endpoint accessed bits, cleared by reading them
  logic [2:0] acc_reg;
  always_ff @(posedge core_clk) begin
    if (reset)
      acc_reg <= 3'h0;
    else if (reg_rd && hit(USC_OFS_EP_ACC))
      acc_reg <= evt.ep_access;
    else
      acc_reg <= acc_reg | evt.ep_access;
  end

  // FIFO control; bus reset clears the whole register
  logic req_reg, tx_reg, clr_reg, setup_reg, empty_packet_flag_reg;
  logic [1:0] sel_reg;
  always_ff @(posedge core_clk) begin
    if (reset || evt.bus_reset) begin
      req_reg <= 1'b0;
      tx_reg <= 1'b0;
      clr_reg <= 1'b0;
      sel_reg <= 2'h0;
      setup_reg <= 1'b0;
      empty_packet_flag_reg <= 1'b0;
    end else begin
      if (wr_fifo) begin
        req_reg <= reg_wdata[USC_B_REQ];
        tx_reg <= reg_wdata[USC_B_TX];
        clr_reg <= reg_wdata[USC_B_CLR];
        sel_reg <= reg_wdata[USC_B_SEL_HI:USC_B_SEL_LO];
        if (!reg_wdata[USC_B_SETUP])
          setup_reg <= 1'b0;
        if (!reg_wdata[USC_B_EMPTY_PACKET_FLAG])
          empty_packet_flag_reg <= 1'b0;
      end
      if (evt.setup_rx)
        setup_reg <= 1'b1;
      if (evt.empty_rx)
        empty_packet_flag_reg <= 1'b1;
    end
  end

  // FIFO command: select 11 is reserved and never requests
  always_comb begin
    fifo_cmd.req = req_reg && sel_reg != 2'h3;
    fifo_cmd.tx = tx_reg;
    fifo_cmd.flush = clr_reg && sel_reg != 2'h3;
    fifo_cmd.sel = sel_reg;
    fifo_cmd.wr = reg_wr && data_hit;
    fifo_cmd.rd = reg_rd && data_hit;
    fifo_cmd.port = reg_addr[1:0];
    fifo_cmd.wdata = reg_wdata;
  end

  // Interrupt pulse; ep0 NAKed accesses are dropped when masked
  logic ep0_irq;
  assign ep0_irq = evt.ep_access[0] && (!nmsk_reg || evt.ep0_data);
  always_ff @(posedge core_clk) begin
    if (reset)
      usb_irq <= 1'b0;
    else
      usb_irq <= bus_suspended_flag_change ||
                 evt.resume_det ||
                 evt.bus_reset ||
                 ep0_irq ||
                 (|evt.ep_access[2:1]);
  end

  // Read mux; write-only bits and reserved bits read zero
  logic [7:0] rd_next;
  always_comb begin
    rd_next = 8'h00;
    unique case (1'b1)
      hit(USC_OFS_STATUS): begin
        rd_next[USC_B_BUS_SUSPENDED_FLAG] = bus_suspended_flag_reg;
        rd_next[USC_B_BUSRST] = busrst_reg;
        rd_next[USC_B_RESUME] = resume_reg;
        rd_next[USC_B_DAT_IN] = line_dm_s && dat_out_reg;
        rd_next[USC_B_CLK_IN] = line_dp_s && clk_out_reg;
      end
      hit(USC_OFS_SELECT): begin
        rd_next[USC_B_LEG_SEL] = leg_sel_reg;
        rd_next[USC_B_SER_SEL] = ser_sel_reg;
      end
      hit(USC_OFS_EP_DIR): rd_next[2:0] = dir_reg;
      hit(USC_OFS_EP_HALT): rd_next[2:0] = halt_reg;
      hit(USC_OFS_EP_ACC): rd_next[2:0] = acc_reg;
      hit(USC_OFS_EP_EN): rd_next[2:0] = en_reg;
      hit(USC_OFS_ENG_STAT): begin
        rd_next[USC_B_ADR_DEF] = adr_def_reg;
        rd_next[USC_B_FIFO_ZERO_ERROR] = fifo_zero_error_reg;
        rd_next[USC_B_OUT] = out_reg;
        rd_next[USC_B_IN] = evt.in_token;
        rd_next[USC_B_NAK] = evt.nak_active;
        rd_next[USC_B_CRC] = crc_reg;
        rd_next[USC_B_NAK_MSK] = nmsk_reg;
      end
      hit(USC_OFS_FIFO_CTL): begin
        rd_next[USC_B_REQ] = req_reg;
        rd_next[USC_B_TX] = tx_reg;
        rd_next[USC_B_CLR] = clr_reg;
        rd_next[USC_B_SEL_HI:USC_B_SEL_LO] = sel_reg;
        rd_next[USC_B_SETUP] = setup_reg;
        rd_next[USC_B_READY] = req_reg && evt.fifo_ready;
        rd_next[USC_B_EMPTY_PACKET_FLAG] = empty_packet_flag_reg;
      end
      data_hit: rd_next = fifo_rdata;
      default: rd_next = 8'h00;
    endcase
  end

  // Registered read data keeps the data output glitch free
  always_ff @(posedge core_clk) begin
    if (reset)
      reg_rdata <= 8'h00;
    else if (reg_rd)
      reg_rdata <= rd_next;
  end

endmodule

// ---- pkg/usc_pkg.sv ----
// Constants and carrier types for the endpoint and suspend control block.
// Assumes one 250 MHz core clock shared with the serial engine logic.
package usc_pkg;

  // Register offsets on the MCU register port
  localparam logic [7:0] USC_OFS_STATUS   = 8'h1A;
  localparam logic [7:0] USC_OFS_SELECT   = 8'h1B;
  localparam logic [7:0] USC_OFS_EP_DIR   = 8'h41;
  localparam logic [7:0] USC_OFS_ADDR     = 8'h42;
  localparam logic [7:0] USC_OFS_EP_HALT  = 8'h43;
  localparam logic [7:0] USC_OFS_EP_ACC   = 8'h44;
  localparam logic [7:0] USC_OFS_ENG_STAT = 8'h45;
  localparam logic [7:0] USC_OFS_FIFO_CTL = 8'h46;
  localparam logic [7:0] USC_OFS_EP_EN    = 8'h47;
  localparam logic [7:0] USC_OFS_DATA0    = 8'h48;
  localparam logic [7:0] USC_OFS_DATA2    = 8'h4A;

  // Status/control register bit positions
  localparam int USC_B_BUS_SUSPENDED_FLAG    = 0;
  localparam int USC_B_WAKE    = 1;
  localparam int USC_B_BUSRST  = 2;
  localparam int USC_B_RESUME  = 3;
  localparam int USC_B_DAT_IN  = 4;
  localparam int USC_B_CLK_IN  = 5;
  localparam int USC_B_DAT_OUT = 6;
  localparam int USC_B_CLK_OUT = 7;
  // Select register bit positions
  localparam int USC_B_LEG_SEL = 4;
  localparam int USC_B_SER_SEL = 5;
  // Engine status bit positions
  localparam int USC_B_ADR_DEF = 0;
  localparam int USC_B_FIFO_ZERO_ERROR  = 1;
  localparam int USC_B_OUT     = 2;
  localparam int USC_B_IN      = 3;
  localparam int USC_B_NAK     = 4;
  localparam int USC_B_CRC     = 5;
  localparam int USC_B_NAK_MSK = 7;
  // FIFO control bit positions
  localparam int USC_B_REQ     = 0;
  localparam int USC_B_TX      = 1;
  localparam int USC_B_CLR     = 2;
  localparam int USC_B_SEL_LO  = 3;
  localparam int USC_B_SEL_HI  = 4;
  localparam int USC_B_SETUP   = 5;
  localparam int USC_B_READY   = 6;
  localparam int USC_B_EMPTY_PACKET_FLAG    = 7;

  // Reset values
  localparam logic [2:0] USC_RST_EP_DIR  = 3'h6;
  localparam logic [2:0] USC_RST_EP_HALT = 3'h6;
  localparam logic [2:0] USC_RST_EP_EN   = 3'h7;
  localparam logic [7:0] USC_RST_ADDR    = 8'h00;

  // Timing: figures as printed, cycle counts derived from the clock rate
  localparam int USC_CLK_MHZ       = 250;
  localparam int USC_RESUME_MS     = 20;
  localparam int USC_RESUME_CLKS   = USC_RESUME_MS * 1000 * USC_CLK_MHZ;
  localparam int USC_WAKE_US       = 2;
  localparam int USC_WAKE_CLKS     = USC_WAKE_US * USC_CLK_MHZ;
  localparam int USC_TOG_INSTR     = 10;
  localparam int USC_INSTR_CLKS    = 4;
  localparam int USC_TOG_CLKS      = USC_TOG_INSTR * USC_INSTR_CLKS;

  // Events and levels reported by the bus-side engine (same clock)
  typedef struct packed {
    logic       suspended;   // Bus idle long enough to suspend
    logic       resume_det;  // Pulse: host resume seen
    logic       bus_reset;   // Pulse: bus reset seen
    logic       in_done;     // Pulse: host read IN data successfully
    logic       endpoint0_data_port_err;   // Pulse: ENDPOINT0_DATA_PORT access error
    logic       crc_err;     // Pulse: CRC error
    logic       out_rx;      // Pulse: non-empty OUT received
    logic       setup_rx;    // Pulse: valid SETUP received
    logic       empty_rx;    // Pulse: zero-length packet received
    logic       in_token;    // Current token is IN
    logic       nak_active;  // Engine answering NAK
    logic [2:0] ep_access;   // Pulse per endpoint accessed
    logic       ep0_data;    // Ep0 access moved real data
    logic       fifo_ready;  // Selected FIFO ready
  } usc_evt_t;

  // Command to the endpoint FIFOs
  typedef struct packed {
    logic       req;
    logic       tx;
    logic       flush;
    logic [1:0] sel;
    logic       wr;          // Pulse: data byte written
    logic       rd;          // Pulse: data byte read
    logic [1:0] port;        // FIFO index of the data access
    logic [7:0] wdata;
  } usc_fifo_cmd_t;

endpackage

// ---- tb/usc_ctrl_properties.sv ----
// Port checker for the endpoint and suspend control block.
// Assumes it is bound to usc_ctrl and sees its ports by name.
module usc_ctrl_properties
  import usc_pkg::*;
#(
  parameter int RESUME_CLKS = USC_RESUME_CLKS
) (
  input wire logic core_clk, // Core clock
  input wire logic reset, // Synchronous reset
  input wire logic [7:0] reg_addr, // Register address
  input wire logic reg_rd, // Read strobe
  input wire usc_evt_t evt, // Engine events
  input wire usc_fifo_cmd_t fifo_cmd, // FIFO command
  input wire logic usb_irq, // Interrupt pulse
  input wire logic wake_enable, // Wake allowed
  input wire logic wake_host, // Wake pulse
  input wire logic toggle_rst, // Toggle reset pulse
  input wire logic [2:0] ep_dir, // Directions
  input wire logic [2:0] ep_en, // Enables
  input wire logic nak_mask, // Ep0 mask
  input wire logic eng_oe, // Engine drive enable
  input wire logic dp_o, // Plus line value
  input wire logic dp_oe // Plus line enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // Interrupt pulses follow their causes by one cycle, and only them
  irq_cause_a: assert property (
    evt.resume_det || evt.bus_reset || $changed(evt.suspended) |=> usb_irq)
    else $error("interrupt missing after bus event");
  ep0_irq_a: assert property (
    evt.ep_access[0] && (!nak_mask || evt.ep0_data) |=> usb_irq)
    else $error("interrupt missing after ep0 access");
  irq_quiet_a: assert property (
    !(evt.resume_det || evt.bus_reset || $changed(evt.suspended) ||
    (|evt.ep_access[2:1]) || (evt.ep_access[0] && (!nak_mask ||
    evt.ep0_data))) |=> !usb_irq) else $error("interrupt without cause");
  // Toggle reset only right after direction bit 0 rises
  toggle_edge_a: assert property (
    toggle_rst |-> ep_dir[0] && !$past(ep_dir[0], 2))
    else $error("toggle reset without rising edge");
  // Wake pulse needs the enable and lasts one cycle
  wake_gate_a: assert property (
    wake_host |-> wake_enable ##1 !wake_host)
    else $error("bad wake pulse");
  legacy_drive_a: assert property (
    dp_oe && !eng_oe |-> !dp_o) else $error("legacy pin driven high");
  ep0_en_a: assert property (ep_en[0])
    else $error("endpoint 0 disabled");
  fifo_sel_a: assert property (
    fifo_cmd.sel == 2'h3 |-> !fifo_cmd.req && !fifo_cmd.flush)
    else $error("reserved select acted on");
  fifo_strobe_a: assert property (
    fifo_cmd.rd == (reg_rd && reg_addr[7:2] == 6'h12 &&
    reg_addr[1:0] != 2'h3)) else $error("bad FIFO read strobe");
  // Main scenarios reached
  cover property (evt.resume_det);
  cover property (toggle_rst);
  cover property (wake_host);
endmodule

// ---- tb/usc_ctrl_test.sv ----
// Self-checking bench for the endpoint and suspend control block.
// Assumes the host model resolves the two line pins.
module usc_ctrl_test
  import usc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic w;
    logic [7:0] a, d, e;
  } usc_row_t;
  logic core_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic eng_dp_o = 1'b1, eng_dm_o = 1'b0, eng_oe = 1'b0;
  logic pull_dp = 1'b0, pull_dm = 1'b0;
  logic usb_irq, wake_enable, wake_host, toggle_rst, nak_mask;
  logic line_dp_s, line_dm_s, dp_i, dp_o, dp_oe, dm_i, dm_o, dm_oe;
  logic [6:0] dev_addr;
  logic [2:0] ep_dir, ep_en, ep_halt;
  usc_evt_t evt = '{fifo_ready: 1'b1, default: '0};
  usc_fifo_cmd_t fifo_cmd;
  logic [7:0] n_irq = 8'h00, n_wake = 8'h00, n_tog = 8'h00, t0;
  int fail_count = 0, n_checks = 0;
  // Reset values, then writes: read/write, read-only, unmapped and write-only places
  usc_row_t rows [15] = '{'{1'b0, 8'h41, 8'h00, 8'h06},
    '{1'b0, 8'h43, 8'h00, 8'h06}, '{1'b0, 8'h44, 8'h00, 8'h00},
    '{1'b0, 8'h47, 8'h00, 8'h07}, '{1'b0, 8'h42, 8'h00, 8'h00},
    '{1'b0, 8'h45, 8'h00, 8'h00}, '{1'b0, 8'h46, 8'h00, 8'h00},
    '{1'b0, 8'h1B, 8'h00, 8'h00}, '{1'b0, 8'h1A, 8'h00, 8'h30},
    '{1'b1, 8'h43, 8'h05, 8'h05}, '{1'b1, 8'h44, 8'hFF, 8'h00},
    '{1'b1, 8'h50, 8'hFF, 8'h00}, '{1'b1, 8'h42, 8'h0B, 8'h00},
    '{1'b1, 8'h47, 8'h05, 8'h05}, '{1'b0, 8'h49, 8'h00, 8'hA5}};

  usc_ctrl #(.RESUME_CLKS(50)) u_usc_ctrl (
    .core_clk, .reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata,
    .evt, .fifo_rdata(8'hA5), .fifo_cmd, .usb_irq, .dev_addr, .wake_enable,
    .wake_host, .toggle_rst, .ep_dir, .ep_en, .ep_halt, .nak_mask, .eng_dp_o,
    .eng_dm_o, .eng_oe, .line_dp_s, .line_dm_s, .dp_i, .dp_o, .dp_oe, .dm_i,
    .dm_o, .dm_oe);
  usc_host_model u_usc_host_model (
    .dp_o, .dp_oe, .dm_o, .dm_oe, .pull_dp, .pull_dm, .dp_i, .dm_i);

  // 4 ns clock
  always #2 core_clk = ~core_clk;
  // Count pulses; the design's pulses last exactly one cycle
  always @(posedge core_clk) begin
    if (usb_irq === 1'b1) n_irq <= n_irq + 8'h01;
    if (wake_host === 1'b1) n_wake <= n_wake + 8'h01;
    if (toggle_rst === 1'b1) n_tog <= n_tog + 8'h01;
  end

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      $display("unexpected at %0t: got %h want %h", $time, g, e);
      fail_count++;
    end
  endtask
  // Bus cycles hold the strobe one edge, then drop it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  // One-cycle engine event pulse
  task automatic ev(input usc_evt_t p);
    @(posedge core_clk);
    evt <= evt | p;
    @(posedge core_clk);
    evt <= evt & ~p;
    #1;
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    chk({1'b0, ep_halt, 1'b0, ep_en}, 8'h55);
    // Suspend, resume, and the resume flag outliving suspend
    @(posedge core_clk) evt.suspended <= 1'b1;
    rd(8'h1A, 8'h31);
    ev('{resume_det: 1'b1, default: '0});
    rd(8'h1A, 8'h39);
    @(posedge core_clk) evt.suspended <= 1'b0;
    rd(8'h1A, 8'h38);
    repeat (60) @(posedge core_clk);
    rd(8'h1A, 8'h30);
    chk(n_irq, 8'h03);
    // FIFO handshake, reserved select, bus reset clearing
    wr(8'h46, 8'h0B);
    rd(8'h46, 8'h4B);
    chk({4'h0, fifo_cmd.req, fifo_cmd.tx, fifo_cmd.sel}, 8'h0D);
    wr(8'h46, 8'h1D);
    chk({6'h00, fifo_cmd.req, fifo_cmd.flush}, 8'h00);
    ev('{bus_reset: 1'b1, default: '0});
    rd(8'h46, 8'h00);
    rd(8'h1A, 8'h34);
    wr(8'h1A, 8'hC0);
    rd(8'h1A, 8'h30);
    // Engine flags: set by events, cleared by firmware or SETUP
    ev('{endpoint0_data_port_err: 1'b1, crc_err: 1'b1, out_rx: 1'b1, default: '0});
    rd(8'h45, 8'h26);
    ev('{setup_rx: 1'b1, default: '0});
    rd(8'h45, 8'h22);
    wr(8'h45, 8'h00);
    @(posedge core_clk) evt <= evt | 16'h0060;
    rd(8'h45, 8'h18);
    @(posedge core_clk) evt <= evt & ~16'h0060;
    // Deferred address waits for a good IN, direct write does not
    wr(8'h45, 8'h01);
    wr(8'h42, 8'h0D);
    chk({1'b0, dev_addr}, 8'h05);
    ev('{in_done: 1'b1, default: '0});
    chk({1'b0, dev_addr}, 8'h06);
    rd(8'h45, 8'h00);
    wr(8'h42, 8'h0F);
    chk({1'b0, dev_addr}, 8'h07);
    // Masked ep0 NAK stays quiet; real transfers interrupt
    wr(8'h45, 8'h80);
    chk({6'h00, nak_mask, wake_enable}, 8'h03);
    ev('{ep_access: 3'h1, default: '0});
    ev('{ep_access: 3'h4, default: '0});
    ev('{ep_access: 3'h1, ep0_data: 1'b1, default: '0});
    repeat (2) @(posedge core_clk);
    chk(n_irq, 8'h06);
    rd(8'h44, 8'h05);
    rd(8'h44, 8'h00);
    // Wake command: a short hold is ignored, one past 2 us is sent
    wr(8'h1A, 8'hC2);
    repeat (100) @(posedge core_clk);
    wr(8'h1A, 8'hC0);
    chk(n_wake, 8'h00);
    wr(8'h1A, 8'hC2);
    repeat (520) @(posedge core_clk);
    wr(8'h1A, 8'hC0);
    repeat (2) @(posedge core_clk);
    chk(n_wake, 8'h01);
    // Short low pulse ignored, long one resets toggles
    wr(8'h41, 8'h07);
    repeat (3) @(posedge core_clk);
    t0 = n_tog;
    wr(8'h41, 8'h06);
    repeat (5) @(posedge core_clk);
    wr(8'h41, 8'h07);
    repeat (3) @(posedge core_clk);
    chk(n_tog, t0);
    wr(8'h41, 8'h06);
    repeat (45) @(posedge core_clk);
    wr(8'h41, 8'h07);
    repeat (3) @(posedge core_clk);
    chk(n_tog, t0 + 8'h01);
    // Legacy pin mode, then serial mode
    wr(8'h1B, 8'h10);
    wr(8'h1A, 8'h40);
    chk({5'h00, dp_oe, dp_o, dm_oe}, 8'h04);
    pull_dm <= 1'b1;
    repeat (3) @(posedge core_clk);
    chk({7'h00, line_dm_s}, 8'h00);
    rd(8'h1A, 8'h00);
    pull_dm <= 1'b0;
    repeat (3) @(posedge core_clk);
    rd(8'h1A, 8'h10);
    wr(8'h1A, 8'h00);
    rd(8'h1A, 8'h00);
    wr(8'h1B, 8'h20);
    @(posedge core_clk) eng_oe <= 1'b1;
    #1 chk({4'h0, dp_oe, dp_o, dm_oe, dm_o}, 8'h0E);
    repeat (3) @(posedge core_clk);
    rd(8'h1A, 8'h00);
    wrap_up();
  end
endmodule

bind usc_ctrl usc_ctrl_properties #(.RESUME_CLKS(RESUME_CLKS)) u_props (
  .core_clk, .reset, .reg_addr, .reg_rd, .evt, .fifo_cmd, .usb_irq,
  .wake_enable, .wake_host, .toggle_rst, .ep_dir, .ep_en, .nak_mask,
  .eng_oe, .dp_o, .dp_oe);

// ---- tb/usc_host_model.sv ----
// Far side of the line pins: pull-ups plus a host that can hold a line low.
// Assumes device enables are high while the device drives a line.
module usc_host_model (
  input wire logic dp_o, // Device plus line value
  input wire logic dp_oe, // Device plus line enable
  input wire logic dm_o, // Device minus line value
  input wire logic dm_oe, // Device minus line enable
  input wire logic pull_dp, // Host holds clock line low
  input wire logic pull_dm, // Host holds data line low
  output logic dp_i, // Resolved plus line
  output logic dm_i // Resolved minus line
);
  timeunit 1ns;
  timeprecision 100ps;
  // Released lines float high; contention is not modelled
  assign dp_i = dp_oe ? dp_o : !pull_dp;
  assign dm_i = dm_oe ? dm_o : !pull_dm;
endmodule
